// [rtl/fcc_top.sv]
// Purpose: Configuration, power-up supervision and fail-safe fan drive
// Assumes: Serial engine runs on CLK_SYS; pins and core sense are async
// Notes:   Summary of operation follows
//
// Summary of operation
// - Frequency bit 0 gives 22.5 kHz drive
// - Frequency bit 1 gives programmable low rate
// - Monitoring starts once core sense is good
// - Without core sense, start after first transaction
// - Fans stay off until programmed, over-limit or fail-safe
// - Over-limit temperature forces full fan speed
// - Unaddressed 4.6 s after core sense: full speed
// - Programming always accepted, then obeyed
// - No core sense never arms the timeout
// - Write without core sense gives normal operation
// - Extended range is -64 to 191 degrees
// - GPIO direction bit: 0 input, 1 output
// - GPIO polarity bit: 0 low, 1 high
// - Pin role from low two bits
// - Shared status bit follows selected pin role
// - Offset spans -64 to +63.5 degrees, half-degree steps
// - Auto loop duty clamped to programmed maximum
// - Fixed slave address 0x2E, no selects
// - Thermal pin timed as input, driven hot
`include "fcc_cfg.svh"
`default_nettype none

module fcc_top
  import fcc_pkg::*;
#(
  parameter int NFAN = 3,
  parameter int unsigned FS_TIMEOUT_CYC = `FCC_FS_TIMEOUT_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire fcc_reg_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic ADDR_VALID,
  input wire logic [6:0] ADDR_BYTE,
  output logic ADDR_ACK,
  input wire logic XFER_DONE,
  input wire logic CPU_CORE_SUPPLY_SENSE_GOOD,
  input wire logic [7:0] TEMP_CODE,
  input wire logic [7:0] TEMP_OFFSET,
  input wire logic [7:0] THERMAL_LIMIT_PIN_LIMIT,
  input wire logic [NFAN*8-1:0] DUTY_CMD,
  input wire logic [7:0] DUTY_MAX,
  input wire logic [15:0] LF_STEP_CYC,
  input wire logic ALERT_REQ,
  input wire logic GPIO_OUT_VAL,
  input wire logic MFP_IN,
  output logic MFP_OUT,
  output logic MFP_OE_N,
  output logic [NFAN-1:0] PWM_OUT,
  output logic MON_EN,
  output logic FAILSAFE,
  output logic OVERTEMP,
  output logic RANGE_LEGACY,
  output logic FAN_LF,
  output logic STATUS_SHARED,
  output logic [15:0] THERMAL_LIMIT_PIN_TIME
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam int CW = $clog2(FS_TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] TMO_LAST = CW'(FS_TIMEOUT_CYC - 1);
  localparam logic [15:0] HF_STEP = 16'(`FCC_HF_STEP_CYC);

  typedef struct packed {
    logic cpu_core_supply_sense_s1;
    logic cpu_core_supply_sense_s2;
    logic mfp_s1;
    logic mfp_s2;
    logic [7:0] cfg5;
    logic [7:0] cfg4;
    logic [7:0] rdata;
    logic addr_ack;
    logic addressed;
    logic mon_en;
    logic programmed;
    fcc_fs_e fs;
    logic [CW-1:0] fs_cnt;
    logic failsafe;
    logic overtemp;
    logic [15:0] step_cnt;
    logic [7:0] phase;
    logic [NFAN-1:0] pwm;
    logic mfp_oe_n;
    logic status;
    logic [15:0] thermal_limit_pin_time;
  } fcc_state_s;

  localparam fcc_state_s RST_STATE = '{
    cfg5: `FCC_RST_CFG5, cfg4: `FCC_RST_CFG4, fs: FS_WAIT, mfp_oe_n: 1'b1, default: '0};

  fcc_state_s st;
  fcc_state_s next_st;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Both values share one coding: offset-64 unsigned or twos complement
  function automatic logic fcc_above(input logic legacy, input logic [7:0] t, input logic [7:0] lim);
    if (legacy) begin
      return $signed(t) > $signed(lim);
    end
    return t > lim;
  endfunction

  function automatic logic [7:0] fcc_clamp(input logic [7:0] cmd, input logic [7:0] lim);
    return (cmd > lim) ? lim : cmd;
  endfunction

  logic legacy;
  logic [7:0] temp_adj;
  logic over_now;
  logic addr_match;
  logic full_now;
  logic [15:0] step_len;
  logic step_wrap;
  fcc_pin_fn_e pin_fn;
  logic gp_level;
  logic [NFAN-1:0] fan_on;

  assign legacy = st.cfg5[`FCC_B_RANGE];
  // Offset LSB is 0.5 degree; the sum wraps, so keep offsets inside the range
  assign temp_adj = TEMP_CODE + {TEMP_OFFSET[7], TEMP_OFFSET[7:1]};
  assign over_now = fcc_above(legacy, temp_adj, THERMAL_LIMIT_PIN_LIMIT);
  assign addr_match = ADDR_VALID && (ADDR_BYTE == `FCC_SLAVE_ADDR);
  assign full_now = over_now || st.failsafe;
  assign step_len = st.cfg5[`FCC_B_LFSEL] ? LF_STEP_CYC : HF_STEP;
  assign step_wrap = (step_len <= 16'h0001) || (st.step_cnt >= step_len - 16'h0001);
  assign pin_fn = fcc_pin_fn_e'(st.cfg4[`FCC_B_FN_HI:`FCC_B_FN_LO]);
  assign gp_level = st.cfg5[`FCC_B_GPPOL] ? GPIO_OUT_VAL : ~GPIO_OUT_VAL;

  // ----------------------------------------
  // Fan drive per channel
  // ----------------------------------------
  // Override only shapes the drive; duty and config registers stay intact
  generate
    for (genvar i = 0; i < NFAN; i++) begin : g_fan
      always_comb begin
        if (full_now) begin
          fan_on[i] = 1'b1;
        end else if (!st.programmed) begin
          fan_on[i] = 1'b0;
        end else begin
          fan_on[i] = st.phase < fcc_clamp(DUTY_CMD[i*8 +: 8], DUTY_MAX);
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.cpu_core_supply_sense_s1 = CPU_CORE_SUPPLY_SENSE_GOOD;
    next_st.cpu_core_supply_sense_s2 = st.cpu_core_supply_sense_s1;
    next_st.mfp_s1 = MFP_IN;
    next_st.mfp_s2 = st.mfp_s1;

    // Register access; writes land whatever the fail-safe state
    if (REG_REQ.wr) begin
      next_st.programmed = 1'b1;
      if (REG_REQ.addr == `FCC_OFS_CFG5) begin
        next_st.cfg5 = REG_REQ.wdata;
      end
      if (REG_REQ.addr == `FCC_OFS_CFG4) begin
        next_st.cfg4 = REG_REQ.wdata;
      end
    end
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `FCC_OFS_CFG5: next_st.rdata = st.cfg5;
        `FCC_OFS_CFG4: next_st.rdata = st.cfg4;
        default: next_st.rdata = `FCC_RD_UNMAPPED;
      endcase
    end

    // Address match and monitoring enable
    next_st.addr_ack = addr_match;
    if (addr_match) begin
      next_st.addressed = 1'b1;
    end else if (XFER_DONE) begin
      next_st.addressed = 1'b0;
    end
    if (st.cpu_core_supply_sense_s2) begin
      next_st.mon_en = 1'b1;
    end
    if (XFER_DONE && st.addressed) begin
      next_st.mon_en = 1'b1;
    end

    // Fail-safe timeout
    case (st.fs)
      FS_WAIT: begin
        if (addr_match || REG_REQ.wr) begin
          next_st.fs = FS_DONE;
        end else if (st.cpu_core_supply_sense_s2) begin
          next_st.fs = FS_COUNT;
          next_st.fs_cnt = '0;
        end
      end
      FS_COUNT: begin
        if (addr_match) begin
          next_st.fs = FS_DONE;
        end else if (st.fs_cnt == TMO_LAST) begin
          next_st.fs = FS_FIRED;
          next_st.failsafe = 1'b1;
        end else begin
          next_st.fs_cnt = st.fs_cnt + 1'b1;
        end
      end
      FS_FIRED: begin
        if (REG_REQ.wr) begin
          next_st.fs = FS_DONE;
          next_st.failsafe = 1'b0;
        end
      end
      FS_DONE: begin
        next_st.failsafe = 1'b0;
      end
      default: begin
        next_st.fs = FS_DONE;
        next_st.failsafe = 1'b0;
      end
    endcase

    // PWM time base, 256 phase steps per period
    if (step_wrap) begin
      next_st.step_cnt = '0;
      next_st.phase = st.phase + 8'h01;
    end else begin
      next_st.step_cnt = st.step_cnt + 16'h0001;
    end
    next_st.pwm = fan_on;
    next_st.overtemp = over_now;
    // Shared pin: open drain, only ever pulled low
    next_st.mfp_oe_n = 1'b1;
    next_st.status = st.mfp_s2;
    case (pin_fn)
      FN_TACH: begin
        next_st.status = st.mfp_s2;
      end
      FN_THERMAL_LIMIT_PIN: begin
        next_st.mfp_oe_n = ~over_now;
        next_st.status = ~st.mfp_s2;
        // Saturating time that the pin has been held low
        if (!st.mfp_s2 && (st.thermal_limit_pin_time != 16'hFFFF)) begin
          next_st.thermal_limit_pin_time = st.thermal_limit_pin_time + 16'h0001;
        end
      end
      FN_ALERT: begin
        next_st.mfp_oe_n = ~ALERT_REQ;
      end
      FN_GPIO: begin
        if (st.cfg5[`FCC_B_GPDIR]) begin
          next_st.mfp_oe_n = gp_level;
        end
        next_st.status = st.cfg5[`FCC_B_GPPOL] ? st.mfp_s2 : ~st.mfp_s2;
      end
      default: begin
        next_st.mfp_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign REG_RDATA = st.rdata;
  assign ADDR_ACK = st.addr_ack;
  assign MFP_OUT = 1'b0;
  assign MFP_OE_N = st.mfp_oe_n;
  assign PWM_OUT = st.pwm;
  assign MON_EN = st.mon_en;
  assign FAILSAFE = st.failsafe;
  assign OVERTEMP = st.overtemp;
  assign RANGE_LEGACY = st.cfg5[`FCC_B_RANGE];
  assign FAN_LF = st.cfg5[`FCC_B_LFSEL];
  assign STATUS_SHARED = st.status;
  assign THERMAL_LIMIT_PIN_TIME = st.thermal_limit_pin_time;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);
  sequence s_wr_cfg5;
    REG_REQ.wr && (REG_REQ.addr == `FCC_OFS_CFG5);
  endsequence
  sequence s_tmo_end;
    (st.fs == FS_COUNT) && (st.fs_cnt == TMO_LAST) && !addr_match;
  endsequence

  property p_freq_sel;
    s_wr_cfg5 |=> (FAN_LF == $past(REG_REQ.wdata[`FCC_B_LFSEL])) && (RANGE_LEGACY == $past(REG_REQ.wdata[0]));
  endproperty
  a_freq_sel: assert property (p_freq_sel) else $error("config write not reflected");

  property p_mon_cpu_core_supply_sense;
    st.cpu_core_supply_sense_s2 |=> MON_EN;
  endproperty
  a_mon_cpu_core_supply_sense: assert property (p_mon_cpu_core_supply_sense) else $error("monitor not enabled by core sense");

  property p_mon_xfer;
    (XFER_DONE && st.addressed) |=> MON_EN;
  endproperty
  a_mon_xfer: assert property (p_mon_xfer) else $error("monitor not enabled after transaction");

  property p_fans_off;
    (!st.programmed && !full_now) |=> (PWM_OUT == '0);
  endproperty
  a_fans_off: assert property (p_fans_off) else $error("fan driven before programming");

  property p_overtemp_full;
    over_now |=> (&PWM_OUT) && OVERTEMP;
  endproperty
  a_overtemp_full: assert property (p_overtemp_full) else $error("overtemp did not force full speed");

  property p_timeout_fire;
    s_tmo_end |=> FAILSAFE ##1 (&PWM_OUT);
  endproperty
  a_timeout_fire: assert property (p_timeout_fire) else $error("timeout did not force full speed");

  property p_write_clears;
    (FAILSAFE && REG_REQ.wr) |=> !FAILSAFE [*2];
  endproperty
  a_write_clears: assert property (p_write_clears) else $error("write did not end fail-safe");

  property p_no_arm;
    (st.fs == FS_WAIT) |=> !FAILSAFE && ((st.fs != FS_COUNT) || $past(st.cpu_core_supply_sense_s2));
  endproperty
  a_no_arm: assert property (p_no_arm) else $error("fail-safe armed without core sense");

  property p_addr_ack;
    ADDR_VALID |=> (ADDR_ACK == ($past(ADDR_BYTE) == `FCC_SLAVE_ADDR));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("slave address match wrong");

  property p_cancel;
    ((st.fs == FS_COUNT) && addr_match) |=> (st.fs == FS_DONE) ##1 !FAILSAFE;
  endproperty
  a_cancel: assert property (p_cancel) else $error("address did not cancel timeout");

  property p_alert_pin;
    ((pin_fn == FN_ALERT) && ALERT_REQ) |=> !MFP_OE_N;
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert role not driving pin");

endmodule : fcc_top

`default_nettype wire

// [rtl/fcc_cfg.svh]
// Purpose: Constants for the fan controller configuration and fail-safe block
// Assumes: 100 MHz system clock
// Notes:   Offsets, bit positions, reset values, bus address, codes and timing counts only
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define FCC_OFS_CFG5 8'h7C
`define FCC_OFS_CFG4 8'h7D
`define FCC_RST_CFG5 8'h00
`define FCC_RST_CFG4 8'h00
`define FCC_RD_UNMAPPED 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FCC_B_RANGE 0
`define FCC_B_LFSEL 1
`define FCC_B_GPDIR 2
`define FCC_B_GPPOL 3
`define FCC_B_FN_LO 0
`define FCC_B_FN_HI 1

// ----------------------------------------
// Bus address and codes
// ----------------------------------------
`define FCC_SLAVE_ADDR 7'h2E
`define FCC_FULL_DUTY 8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define FCC_CLK_HZ 100000000
`define FCC_HIGH_RATE_FAN_DRIVE_HZ 22500
`define FCC_PWM_STEPS 256
`define FCC_HF_STEP_CYC (`FCC_CLK_HZ / (`FCC_HIGH_RATE_FAN_DRIVE_HZ * `FCC_PWM_STEPS))
`define FCC_FS_TIMEOUT_MS 4600
`define FCC_FS_TIMEOUT_CYC (`FCC_FS_TIMEOUT_MS * (`FCC_CLK_HZ / 1000))

`endif

// [rtl/fcc_pkg.sv]
// Purpose: Types shared by the fan controller configuration block
// Assumes: Constants come from fcc_cfg.svh
// Notes:   Types only
`default_nettype none

package fcc_pkg;

  // ----------------------------------------
  // Register request from the serial engine
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fcc_reg_req_s;

  // ----------------------------------------
  // Shared pin role and fail-safe timer
  // ----------------------------------------
  typedef enum logic [1:0] {FN_TACH, FN_THERMAL_LIMIT_PIN, FN_ALERT, FN_GPIO} fcc_pin_fn_e;
  typedef enum logic [1:0] {FS_WAIT, FS_COUNT, FS_FIRED, FS_DONE} fcc_fs_e;

endpackage : fcc_pkg

`default_nettype wire

// [tb/fcc_host_model.sv]
// Purpose: Host side model driving register, address and stop strobes
// Assumes: Strobes change on the falling clock edge only
// Notes:   Idle lines carry inverted data so stale values never match
`default_nettype none

module fcc_host_model
  import fcc_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  input wire logic ack,
  output fcc_reg_req_s req,
  output logic addr_valid,
  output logic [6:0] addr_byte,
  output logic xfer_done
);
  int gap = 0;

  initial begin
    req = '0;
    addr_valid = 1'b0;
    addr_byte = 7'h00;
    xfer_done = 1'b0;
  end

  // Gap lets the host answer slowly between requests
  task automatic pulse_req(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    req = {w, ~w, a, d};
    @(negedge clk);
    q = rdata;
    req = {2'b00, ~a, ~d};
    repeat (gap) @(negedge clk);
  endtask

  task automatic send_addr(input logic [6:0] a, output logic k);
    @(negedge clk);
    addr_valid = 1'b1;
    addr_byte = a;
    @(negedge clk);
    k = ack;
    addr_valid = 1'b0;
    addr_byte = ~a;
  endtask

  task automatic end_xfer();
    @(negedge clk);
    xfer_done = 1'b1;
    @(negedge clk);
    xfer_done = 1'b0;
  endtask
endmodule // fcc_host_model

`default_nettype wire

// [tb/fcc_top_bench.sv]
// Purpose: Self-checking bench for configuration and fail-safe logic
// Assumes: Short fail-safe timeout parameter keeps the run brief
// Notes:   Register model is an associative array keyed by offset
`include "fcc_cfg.svh"
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", nm, ex, gt); end end

module fcc_top_bench
  import fcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NF = 3;
  localparam int FS = 200;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  fcc_reg_req_s req;
  logic [6:0] addr_byte;
  logic addr_valid, addr_ack, xfer_done, cpu_core_supply_sense_good, alert_req, gpio_out_val, mfp_ext, mfp_out, mfp_oe_n;
  logic mon_en, failsafe, overtemp, range_legacy, fan_lf, status_shared, ak;
  logic [7:0] rdata, rd, temp_code, temp_offset, thermal_limit_pin_limit, duty_max, d;
  logic [NF*8-1:0] duty_cmd;
  logic [NF-1:0] pwm_out;
  logic [15:0] lf_step_cyc, thermal_limit_pin_time, t0;
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 48;
  int mdl_reg[int];
  int n, i, k;
  // Open-drain pin: low whenever the block pulls it
  wire logic mfp_pin = (mfp_oe_n === 1'b0) ? mfp_out : mfp_ext;

  always #5 clk_sys = ~clk_sys;

  fcc_top #(.NFAN(NF), .FS_TIMEOUT_CYC(FS)) fcc_top_inst (.CLK_SYS(clk_sys), .SRST(srst), .REG_REQ(req),
    .REG_RDATA(rdata), .ADDR_VALID(addr_valid), .ADDR_BYTE(addr_byte), .ADDR_ACK(addr_ack),
    .XFER_DONE(xfer_done), .CPU_CORE_SUPPLY_SENSE_GOOD(cpu_core_supply_sense_good), .TEMP_CODE(temp_code), .TEMP_OFFSET(temp_offset),
    .THERMAL_LIMIT_PIN_LIMIT(thermal_limit_pin_limit), .DUTY_CMD(duty_cmd), .DUTY_MAX(duty_max), .LF_STEP_CYC(lf_step_cyc),
    .ALERT_REQ(alert_req), .GPIO_OUT_VAL(gpio_out_val), .MFP_IN(mfp_pin), .MFP_OUT(mfp_out),
    .MFP_OE_N(mfp_oe_n), .PWM_OUT(pwm_out), .MON_EN(mon_en), .FAILSAFE(failsafe), .OVERTEMP(overtemp),
    .RANGE_LEGACY(range_legacy), .FAN_LF(fan_lf), .STATUS_SHARED(status_shared), .THERMAL_LIMIT_PIN_TIME(thermal_limit_pin_time));

  fcc_host_model fcc_host_model_inst (.clk(clk_sys), .rdata(rdata), .ack(addr_ack), .req(req),
    .addr_valid(addr_valid), .addr_byte(addr_byte), .xfer_done(xfer_done));

  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  task automatic do_reset();
    srst = 1'b1;
    cpu_core_supply_sense_good = 1'b0;
    tick(20);
    srst = 1'b0;
    mdl_reg.delete();
    mdl_reg[8'h7C] = 0;
    mdl_reg[8'h7D] = 0;
    tick(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    fcc_host_model_inst.pulse_req(1'b1, a, v, rd);
    if (mdl_reg.exists(a)) mdl_reg[a] = v;
    tick(1);
  endtask

  task automatic rdchk(input logic [7:0] a);
    fcc_host_model_inst.pulse_req(1'b0, a, 8'h00, rd);
    `CHK("rdata", 8'(mdl_reg.exists(a) ? mdl_reg[a] : 0), rd)
  endtask

  task automatic cnt_hi(input int len);
    n = 0;
    repeat (len) begin
      @(negedge clk_sys);
      n += pwm_out[0];
    end
  endtask

  initial begin
    #900us;
    error_cnt++;
    final_report();
  end

  initial begin
    {alert_req, gpio_out_val, cpu_core_supply_sense_good} = 3'b000;
    mfp_ext = 1'b1;
    {temp_code, temp_offset, thermal_limit_pin_limit, duty_max} = {8'h10, 8'h00, 8'h80, 8'hFF};
    duty_cmd = '1;
    lf_step_cyc = 16'h0004;
    do_reset();
    tick(FS + 100);
    `CHK("pwm", 3'h0, pwm_out)
    `CHK("fan_lf", 1'b0, fan_lf)
    `CHK("range", 1'b0, range_legacy)
    `CHK("failsafe", 1'b0, failsafe)
    `CHK("mon_en", 1'b0, mon_en)
    rdchk(8'h7C);
    $display("Test reset done");
    fcc_host_model_inst.send_addr(7'h2D, ak);
    `CHK("ack", 1'b0, ak)
    fcc_host_model_inst.send_addr(7'h2E, ak);
    `CHK("ack", 1'b1, ak)
    fcc_host_model_inst.end_xfer();
    tick(1);
    `CHK("mon_en", 1'b1, mon_en)
    $display("Test address done");
    fcc_host_model_inst.gap = 2;
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed)) & 8'h0F;
      wr(8'h7C, d);
      `CHK("range", d[0], range_legacy)
      `CHK("fan_lf", d[1], fan_lf)
      rdchk(8'h7C);
      wr(8'h7D, 8'(i));
      rdchk(8'h7D);
    end
    wr(8'h55, 8'($random(seed)));
    rdchk(8'h55);
    fcc_host_model_inst.gap = 0;
    $display("Test registers done");
    wr(8'h7C, 8'h00);
    for (k = 0; k < 3; k++) begin
      duty_cmd[7:0] = (k == 1) ? 8'h30 : 8'hFF;
      duty_max = (k == 1) ? 8'hFF : (8'($random(seed)) & 8'h7F) + 8'h01;
      if (k == 2) wr(8'h7C, 8'h02);
      tick(2);
      cnt_hi((k == 2) ? 1024 : 256 * `FCC_HF_STEP_CYC);
      d = (duty_cmd[7:0] < duty_max) ? duty_cmd[7:0] : duty_max;
      `CHK("duty", d * ((k == 2) ? 4 : `FCC_HF_STEP_CYC), n)
    end
    $display("Test drive done");
    duty_max = 8'h00;
    wr(8'h7C, 8'h00);
    wr(8'h7D, 8'h01);
    temp_code = 8'h90;
    tick(4);
    `CHK("overtemp", 1'b1, overtemp)
    `CHK("pwm", 3'h7, pwm_out)
    `CHK("pin_oe_n", 1'b0, mfp_oe_n)
    `CHK("pin_out", 1'b0, mfp_out)
    temp_code = 8'h10;
    tick(4);
    `CHK("pwm", 3'h0, pwm_out)
    {temp_code, temp_offset} = {8'h70, 8'h40};
    tick(4);
    `CHK("overtemp", 1'b1, overtemp)
    {temp_code, temp_offset} = {8'hA0, 8'hC0};
    tick(4);
    `CHK("overtemp", 1'b0, overtemp)
    {temp_code, temp_offset} = {8'h10, 8'h00};
    tick(4);
    thermal_limit_pin_limit = 8'h40;
    wr(8'h7C, 8'h01);
    temp_code = 8'h90;
    tick(4);
    `CHK("overtemp", 1'b0, overtemp)
    temp_code = 8'h10;
    wr(8'h7C, 8'h00);
    t0 = thermal_limit_pin_time;
    #3;
    repeat (40) #80 mfp_ext = ~mfp_ext;
    tick(6);
    `CHK("thermal_limit_pin_time", 1'b1, (thermal_limit_pin_time - t0 >= 16'd155) && (thermal_limit_pin_time - t0 <= 16'd165))
    mfp_ext = 1'b0;
    tick(4);
    `CHK("status", 1'b1, status_shared)
    mfp_ext = 1'b1;
    $display("Test thermal done");
    wr(8'h7D, 8'h03);
    for (k = 0; k < 4; k++) begin
      wr(8'h7C, {4'h0, k[1], 3'h0});
      mfp_ext = k[0];
      tick(5);
      `CHK("status", k[0] ~^ k[1], status_shared)
    end
    wr(8'h7C, 8'h0C);
    gpio_out_val = 1'b0;
    tick(3);
    `CHK("pin_oe_n", 1'b0, mfp_oe_n)
    gpio_out_val = 1'b1;
    tick(3);
    `CHK("pin_oe_n", 1'b1, mfp_oe_n)
    wr(8'h7D, 8'h02);
    alert_req = 1'b1;
    tick(3);
    `CHK("pin_oe_n", 1'b0, mfp_oe_n)
    alert_req = 1'b0;
    $display("Test pin done");
    do_reset();
    cpu_core_supply_sense_good = 1'b1;
    tick(4);
    `CHK("mon_en", 1'b1, mon_en)
    for (k = 0; k < 400 && failsafe !== 1'b1; k++) tick(1);
    if (k == 400) begin
      error_cnt++;
      final_report();
    end
    `CHK("fs_early", 1'b1, (k >= FS - 2) && (k <= FS))
    tick(2);
    `CHK("pwm", 3'h7, pwm_out)
    wr(8'h7C, 8'h02);
    `CHK("failsafe", 1'b0, failsafe)
    `CHK("pwm", 3'h0, pwm_out)
    `CHK("fan_lf", 1'b1, fan_lf)
    do_reset();
    cpu_core_supply_sense_good = 1'b1;
    tick(4);
    fcc_host_model_inst.send_addr(7'h2E, ak);
    `CHK("ack", 1'b1, ak)
    tick(FS + 100);
    `CHK("failsafe", 1'b0, failsafe)
    $display("Test fail-safe done");
    final_report();
  end
endmodule // fcc_top_bench

`default_nettype wire
